// File: hdl/lrnr_top.sv
// Added by the designer: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "lrnr_map.svh"

// Notes on behaviour
// - candidate sets of four or fewer rates never need recovery
// - in negotiation state, master requests reconfiguration to the final rate
// - hang-up detection armed only when full set exceeds four options
// - hang-up found by timer or by failed round-robin pass count
// - reduce mode: restrict to four rates, then restart rate search
// - reduced set failing: optionally move to second group of four
// - wait mode: master alone waits before restarting rate search
// - wait recovery repeats with a waiting time varying per attempt
module lrnr_top #(
  parameter logic [31:0] DWELL_RST_CYC = 32'(`LRNR_DWELL_CYC),
  parameter logic [31:0] TMO_RST_CYC   = 32'(`LRNR_TMO_CYC),
  parameter logic [31:0] WAIT_RST_CYC  = 32'(`LRNR_WAIT_CYC)
) (
  // clock and reset
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  // ahb-lite slave
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic [31:0]                 hrdata,
  output logic                        hreadyout,
  output logic                        hresp,
  // start-up state machine
  input  wire lrnr_pkg::lrnr_fsm_in_t fsm_in,
  output lrnr_pkg::lrnr_fsm_out_t     fsm_out,
  // interrupt
  output logic                        irq
);
  import lrnr_pkg::*;

  function automatic logic [3:0] lrnr_popcnt(input logic [7:0] m);
    logic [3:0] c;
    c = 4'h0;
    for (int i = 0; i < 8; i++) begin
      c = c + {3'h0, m[i]};
    end
    return c;
  endfunction

  // keeps the lowest four candidates of a mask
  function automatic logic [7:0] lrnr_limit4(input logic [7:0] m);
    logic [7:0] r;
    logic [3:0] c;
    r = 8'h00;
    c = 4'h0;
    for (int i = 0; i < 8; i++) begin
      if (m[i] && c < `LRNR_SAFE_OPTS) begin
        r[i] = 1'b1;
        c = c + 4'h1;
      end
    end
    return r;
  endfunction

  // next candidate after cur, circular; cur kept if mask empty
  function automatic logic [2:0] lrnr_next(input logic [7:0] m, input logic [2:0] cur);
    logic [2:0] r;
    logic [2:0] idx;
    logic       hit;
    r = cur;
    hit = 1'b0;
    for (int i = 1; i <= 8; i++) begin
      idx = cur + 3'(i);
      if (m[idx] && !hit) begin
        r = idx;
        hit = 1'b1;
      end
    end
    return r;
  endfunction

  // bus registers
  logic        wr_pend_ff;
  logic [11:0] wr_addr_ff;
  lrnr_ctrl_t  ctrl_ff;
  logic [7:0]  full_ff;
  logic [7:0]  seta_ff;
  logic [7:0]  setb_ff;
  logic [31:0] dwell_cfg_ff;
  logic [31:0] tmo_cfg_ff;
  logic [7:0]  pass_cfg_ff;
  logic [3:0]  retry_cfg_ff;
  logic [31:0] wait_cfg_ff;
  logic [2:0]  final_ff;
  logic [3:0]  irq_sts_ff;
  logic [3:0]  irq_en_ff;
  logic        go_pend_ff;
  // engine
  lrnr_state_t state_ff;
  lrnr_state_t nxt_state;
  logic [1:0]  stage_ff;
  logic [2:0]  rate_ff;
  logic [31:0] dwell_ff;
  logic [31:0] hang_ff;
  logic [7:0]  pass_ff;
  logic [31:0] wait_ff;
  logic [3:0]  attempt_ff;
  lrnr_fsm_out_t out_ff;

  // address decode
  wire        addr_take = hsel & htrans[1] & hready;
  wire        wr_take   = addr_take & hwrite;
  wire        rd_take   = addr_take & ~hwrite;
  wire [11:0] rd_ofs    = haddr[11:0];
  wire        wr_en     = wr_pend_ff;
  wire        w_ctrl    = wr_en && wr_addr_ff == `LRNR_CTRL_OFS;
  wire        w_full    = wr_en && wr_addr_ff == `LRNR_FULLSET_OFS;
  wire        w_seta    = wr_en && wr_addr_ff == `LRNR_SETA_OFS;
  wire        w_setb    = wr_en && wr_addr_ff == `LRNR_SETB_OFS;
  wire        w_dwell   = wr_en && wr_addr_ff == `LRNR_DWELL_OFS;
  wire        w_tmo     = wr_en && wr_addr_ff == `LRNR_TMO_OFS;
  wire        w_pass    = wr_en && wr_addr_ff == `LRNR_PASS_OFS;
  wire        w_wait    = wr_en && wr_addr_ff == `LRNR_WAIT_OFS;
  wire        w_final   = wr_en && wr_addr_ff == `LRNR_FINAL_OFS;
  wire        w_irqclr  = wr_en && wr_addr_ff == `LRNR_IRQCLR_OFS;
  wire        w_irqen   = wr_en && wr_addr_ff == `LRNR_IRQEN_OFS;
  wire        go_wr     = w_ctrl & hwdata[`LRNR_CTRL_GO];

  wire [31:0] status_word = {8'h00, attempt_ff, pass_ff, 1'b0, rate_ff,
                             2'h0, stage_ff, 1'b0, state_ff};
  wire [31:0] rd_mux =
    (rd_ofs == `LRNR_CTRL_OFS)    ? {28'h0, ctrl_ff} :
    (rd_ofs == `LRNR_FULLSET_OFS) ? {24'h0, full_ff} :
    (rd_ofs == `LRNR_SETA_OFS)    ? {24'h0, seta_ff} :
    (rd_ofs == `LRNR_SETB_OFS)    ? {24'h0, setb_ff} :
    (rd_ofs == `LRNR_DWELL_OFS)   ? dwell_cfg_ff :
    (rd_ofs == `LRNR_TMO_OFS)     ? tmo_cfg_ff :
    (rd_ofs == `LRNR_PASS_OFS)    ? {20'h0, retry_cfg_ff, pass_cfg_ff} :
    (rd_ofs == `LRNR_WAIT_OFS)    ? wait_cfg_ff :
    (rd_ofs == `LRNR_FINAL_OFS)   ? {29'h0, final_ff} :
    (rd_ofs == `LRNR_STATUS_OFS)  ? status_word :
    (rd_ofs == `LRNR_IRQSTS_OFS)  ? {28'h0, irq_sts_ff} :
    (rd_ofs == `LRNR_IRQEN_OFS)   ? {28'h0, irq_en_ff} : 32'h0;

  // candidate set in use
  wire [7:0] grp_mask = (stage_ff == 2'h1) ? seta_ff : setb_ff;
  wire [7:0] act_mask = (stage_ff == 2'h0) ? full_ff : lrnr_limit4(grp_mask);
  wire [2:0] rate_nxt = lrnr_next(act_mask, rate_ff);
  wire [2:0] rate_1st = lrnr_next(act_mask, 3'h7);
  wire       dwell_end = dwell_ff >= dwell_cfg_ff;
  wire       in_search = state_ff == LRNR_SEARCH;
  // recovery only with more than four candidates
  wire       armed = lrnr_popcnt(full_ff) > `LRNR_SAFE_OPTS;
  wire       hang_hit = ctrl_ff.det_timer ? (hang_ff >= tmo_cfg_ff)
                                          : (pass_ff >= pass_cfg_ff);
  wire       hang_ev = armed & in_search & ~fsm_in.rate_locked & hang_hit;
  wire       lock_ev = in_search & fsm_in.rate_locked;
  wire       pass_end = in_search & dwell_end & (rate_nxt <= rate_ff);
  wire       stage_up = ~ctrl_ff.mode_wait &
                        ((stage_ff == 2'h0) | ((stage_ff == 2'h1) & ctrl_ff.alt_en));
  wire       retry_ok = attempt_ff < retry_cfg_ff;
  wire       exh_ev = hang_ev & (ctrl_ff.mode_wait ? ~retry_ok : ~stage_up);
  wire [31:0] wait_len = wait_cfg_ff << attempt_ff[1:0];
  wire       recfg_ev = (state_ff == LRNR_LINKED) & fsm_in.neg_state & go_pend_ff;
  wire [3:0] irq_set = {recfg_ev, exh_ev, lock_ev, hang_ev};
  wire       restart_now = state_ff == LRNR_RESTART;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      LRNR_IDLE:
        if (ctrl_ff.enable && fsm_in.search_active) begin
          nxt_state = LRNR_RESTART;
        end
      LRNR_SEARCH:
        if (!ctrl_ff.enable) begin
          nxt_state = LRNR_IDLE;
        end else if (fsm_in.rate_locked) begin
          nxt_state = LRNR_LINKED;
        end else if (hang_ev) begin
          nxt_state = (ctrl_ff.mode_wait && retry_ok) ? LRNR_WAIT : LRNR_RESTART;
        end
      LRNR_WAIT:
        if (!ctrl_ff.enable) begin
          nxt_state = LRNR_IDLE;
        end else if (wait_ff == 32'h0) begin
          nxt_state = LRNR_RESTART;
        end
      LRNR_RESTART:
        nxt_state = LRNR_SEARCH;
      LRNR_LINKED:
        if (!ctrl_ff.enable) begin
          nxt_state = LRNR_IDLE;
        end else if (fsm_in.search_active && !fsm_in.neg_state) begin
          nxt_state = LRNR_RESTART;
        end
      default:
        nxt_state = LRNR_IDLE;
    endcase
  end

  // bus front end, zero wait states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 12'h000;
      hrdata     <= 32'h0;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
    end else begin
      wr_pend_ff <= wr_take;
      wr_addr_ff <= wr_take ? haddr[11:0] : wr_addr_ff;
      hrdata     <= rd_take ? rd_mux : 32'h0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff      <= '0;
      full_ff      <= `LRNR_FULLSET_RST;
      seta_ff      <= `LRNR_SETA_RST;
      setb_ff      <= `LRNR_SETB_RST;
      dwell_cfg_ff <= DWELL_RST_CYC;
      tmo_cfg_ff   <= TMO_RST_CYC;
      pass_cfg_ff  <= `LRNR_PASS_RST;
      retry_cfg_ff <= `LRNR_RETRY_RST;
      wait_cfg_ff  <= WAIT_RST_CYC;
      final_ff     <= 3'h0;
      irq_en_ff    <= 4'h0;
    end else begin
      if (w_ctrl)  ctrl_ff <= lrnr_ctrl_t'(hwdata[3:0]);
      if (w_full)  full_ff <= hwdata[7:0];
      if (w_seta)  seta_ff <= hwdata[7:0];
      if (w_setb)  setb_ff <= hwdata[7:0];
      if (w_dwell) dwell_cfg_ff <= hwdata;
      if (w_tmo)   tmo_cfg_ff <= hwdata;
      if (w_pass)  pass_cfg_ff <= hwdata[7:0];
      if (w_pass)  retry_cfg_ff <= hwdata[11:8];
      if (w_wait)  wait_cfg_ff <= hwdata;
      if (w_final) final_ff <= hwdata[2:0];
      if (w_irqen) irq_en_ff <= hwdata[3:0];
    end
  end

  // sticky events: a new event beats a clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_sts_ff <= 4'h0;
      irq        <= 1'b0;
      go_pend_ff <= 1'b0;
    end else begin
      irq_sts_ff <= (irq_sts_ff & ~(w_irqclr ? hwdata[3:0] : 4'h0)) | irq_set;
      irq        <= |(irq_sts_ff & irq_en_ff);
      go_pend_ff <= go_wr | (go_pend_ff & ~recfg_ev);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff   <= LRNR_IDLE;
      stage_ff   <= 2'h0;
      attempt_ff <= 4'h0;
      wait_ff    <= 32'h0;
    end else begin
      state_ff <= nxt_state;
      if (state_ff == LRNR_IDLE || lock_ev) begin
        stage_ff   <= 2'h0;
        attempt_ff <= 4'h0;
      end else if (hang_ev) begin
        // fall back to a four-rate set
        if (stage_up) stage_ff <= stage_ff + 2'h1;
        if (ctrl_ff.mode_wait) attempt_ff <= retry_ok ? attempt_ff + 4'h1 : 4'h0;
      end
      if (hang_ev) begin
        wait_ff <= wait_len;
      end else if (state_ff == LRNR_WAIT && wait_ff != 32'h0) begin
        wait_ff <= wait_ff - 32'h1;
      end
    end
  end

  // round robin stepping and hang-up watch
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rate_ff  <= 3'h0;
      dwell_ff <= 32'h0;
      hang_ff  <= 32'h0;
      pass_ff  <= 8'h0;
    end else if (restart_now || lock_ev) begin
      rate_ff  <= restart_now ? rate_1st : rate_ff;
      dwell_ff <= 32'h0;
      hang_ff  <= 32'h0;
      pass_ff  <= 8'h0;
    end else if (in_search) begin
      dwell_ff <= dwell_end ? 32'h0 : dwell_ff + 32'h1;
      rate_ff  <= dwell_end ? rate_nxt : rate_ff;
      hang_ff  <= (hang_ff == 32'hFFFF_FFFF) ? hang_ff : hang_ff + 32'h1;
      pass_ff  <= (pass_end && pass_ff != 8'hFF) ? pass_ff + 8'h1 : pass_ff;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_ff <= '0;
    end else begin
      out_ff.restart_search <= restart_now;
      out_ff.reconfig_req   <= recfg_ev;
      out_ff.reconfig_rate  <= recfg_ev ? final_ff : out_ff.reconfig_rate;
      out_ff.rate_option    <= rate_ff;
      out_ff.hangup         <= hang_ev;
    end
  end

  assign fsm_out = out_ff;
endmodule

// File: hdl/lrnr_map.svh
`ifndef LRNR_MAP_SVH
`define LRNR_MAP_SVH

// register byte offsets
`define LRNR_CTRL_OFS     12'h000
`define LRNR_FULLSET_OFS  12'h004
`define LRNR_SETA_OFS     12'h008
`define LRNR_SETB_OFS     12'h00C
`define LRNR_DWELL_OFS    12'h010
`define LRNR_TMO_OFS      12'h014
`define LRNR_PASS_OFS     12'h018
`define LRNR_WAIT_OFS     12'h01C
`define LRNR_FINAL_OFS    12'h020
`define LRNR_STATUS_OFS   12'h024
`define LRNR_IRQSTS_OFS   12'h028
`define LRNR_IRQCLR_OFS   12'h02C
`define LRNR_IRQEN_OFS    12'h030

// control fields
`define LRNR_CTRL_EN      0
`define LRNR_CTRL_WAITM   1
`define LRNR_CTRL_DETTMR  2
`define LRNR_CTRL_ALTEN   3
`define LRNR_CTRL_GO      4

// interrupt bits
`define LRNR_IRQ_HANG     0
`define LRNR_IRQ_LOCK     1
`define LRNR_IRQ_EXH      2
`define LRNR_IRQ_RECFG    3
`define LRNR_IRQ_W        4

// sizes
`define LRNR_OPT_W        3
`define LRNR_MASK_W       8
`define LRNR_SAFE_OPTS    4'h4

// reset values
`define LRNR_FULLSET_RST  8'h1F
`define LRNR_SETA_RST     8'h0F
`define LRNR_SETB_RST     8'h1E
`define LRNR_PASS_RST     8'h04
`define LRNR_RETRY_RST    4'h4

// timing, clock 40 MHz
`define LRNR_CLK_KHZ      40000
`define LRNR_DWELL_MS     1000
`define LRNR_TMO_MS       20000
`define LRNR_WAIT_MS      3000
`define LRNR_DWELL_CYC    (`LRNR_DWELL_MS * `LRNR_CLK_KHZ)
`define LRNR_TMO_CYC      (`LRNR_TMO_MS * `LRNR_CLK_KHZ)
`define LRNR_WAIT_CYC     (`LRNR_WAIT_MS * `LRNR_CLK_KHZ)

`endif

// File: hdl/lrnr_pkg.sv
package lrnr_pkg;
  // gray steps along idle, restart, search, linked; wait one step off search
  typedef enum logic [2:0] {
    LRNR_IDLE    = 3'h0,
    LRNR_RESTART = 3'h1,
    LRNR_SEARCH  = 3'h3,
    LRNR_LINKED  = 3'h2,
    LRNR_WAIT    = 3'h7
  } lrnr_state_t;

  // inputs from the start-up state machine
  typedef struct packed {
    logic search_active;
    logic rate_locked;
    logic neg_state;
  } lrnr_fsm_in_t;

  // commands towards the start-up state machine
  typedef struct packed {
    logic       restart_search;
    logic       reconfig_req;
    logic [2:0] reconfig_rate;
    logic [2:0] rate_option;
    logic       hangup;
  } lrnr_fsm_out_t;

  typedef struct packed {
    logic alt_en;
    logic det_timer;
    logic mode_wait;
    logic enable;
  } lrnr_ctrl_t;
endpackage

// File: tb/lrnr_top_sva.sv
`timescale 1ns/1ps
module lrnr_chk (
  // clock and reset
  input wire logic                    hclk,
  input wire logic                    hresetn,
  // bus
  input wire logic                    hsel,
  input wire logic [1:0]              htrans,
  input wire logic                    hwrite,
  input wire logic                    hready,
  input wire logic [31:0]             hrdata,
  input wire logic                    hreadyout,
  input wire logic                    hresp,
  // start-up machine
  input wire lrnr_pkg::lrnr_fsm_in_t  fsm_in,
  input wire lrnr_pkg::lrnr_fsm_out_t fsm_out
);
  import lrnr_pkg::*;
  logic rd_take;
  assign rd_take = hsel & htrans[1] & hready & ~hwrite;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_once(sig);
    sig ##1 !sig;
  endsequence
  ready_high_a: assert property (hreadyout) else $error("hreadyout low");
  resp_okay_a: assert property (!hresp) else $error("hresp not okay");
  rdata_idle_a: assert property (!$past(rd_take) |-> hrdata == 32'h0)
    else $error("hrdata not zero");
  restart_pulse_a: assert property (
    fsm_out.restart_search |-> s_once(fsm_out.restart_search)) else $error("restart long");
  hang_pulse_a: assert property (
    fsm_out.hangup |-> s_once(fsm_out.hangup)) else $error("hangup long");
  recfg_pulse_a: assert property (
    fsm_out.reconfig_req |-> s_once(fsm_out.reconfig_req)) else $error("reconfig long");
  recfg_neg_a: assert property (
    fsm_out.reconfig_req |-> $past(fsm_in.neg_state)) else $error("reconfig off state");
  rate_hold_a: assert property (
    fsm_out.reconfig_req |=> $stable(fsm_out.reconfig_rate)) else $error("rate moved");
endmodule

bind lrnr_top lrnr_chk lrnr_chk_i (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .fsm_in(fsm_in), .fsm_out(fsm_out)
);

// File: tb/lrnr_fsm_model.sv
`timescale 1ns/1ps
module lrnr_fsm_model (
  // clock and reset
  input  wire logic                    hclk,
  input  wire logic                    hresetn,
  // bench controls
  input  wire logic                    lock_en,
  input  wire logic [2:0]              lock_rate,
  input  wire logic                    neg_req,
  output logic [2:0]                   cur_rate,
  // block side
  input  wire lrnr_pkg::lrnr_fsm_out_t fsm_out,
  output lrnr_pkg::lrnr_fsm_in_t       fsm_in
);
  import lrnr_pkg::*;
  logic locked_ff;
  assign fsm_in.search_active = ~locked_ff;
  // far side offers one common rate
  assign fsm_in.rate_locked = ~locked_ff & lock_en & (fsm_out.rate_option == lock_rate);
  assign fsm_in.neg_state = locked_ff & neg_req;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      locked_ff <= 1'b0;
      cur_rate <= 3'h0;
    end else begin
      // dropping lock_en models a lost link
      locked_ff <= (locked_ff | fsm_in.rate_locked) & lock_en & ~fsm_out.restart_search;
      if (fsm_out.reconfig_req) begin
        cur_rate <= fsm_out.reconfig_rate;
      end
    end
  end
endmodule

// File: tb/tb.sv
`timescale 1ns/1ps
`include "lrnr_map.svh"
module tb;
  import lrnr_pkg::*;
  logic          hclk;
  logic          hresetn;
  logic          hsel;
  logic [31:0]   haddr;
  logic [1:0]    htrans;
  logic          hwrite;
  logic [2:0]    hsize;
  logic [31:0]   hwdata;
  wire           hready;
  logic [31:0]   hrdata;
  logic          hreadyout;
  logic          hresp;
  lrnr_fsm_in_t  fsm_in;
  lrnr_fsm_out_t fsm_out;
  logic          irq;
  logic          lock_en;
  logic [2:0]    lock_rate;
  logic          neg_req;
  logic [2:0]    cur_rate;
  logic [31:0]   q;
  int            n;
  int            g1;
  int            err_total = 0;
  int            check_count = 0;

  assign hready = hreadyout;
  lrnr_top #(.DWELL_RST_CYC(32'h4), .TMO_RST_CYC(32'hC8), .WAIT_RST_CYC(32'h14)) lrnr_top_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .fsm_in(fsm_in), .fsm_out(fsm_out), .irq(irq));
  lrnr_fsm_model lrnr_fsm_model_i (
    .hclk(hclk), .hresetn(hresetn), .lock_en(lock_en), .lock_rate(lock_rate),
    .neg_req(neg_req), .cur_rate(cur_rate), .fsm_out(fsm_out), .fsm_in(fsm_in));

  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a);
    bus(1'b0, a, 32'h0);
  endtask

  // events: 0 hangup, 1 reconfig, 2 restart, 3 lock
  task automatic wait_ev(input int sel, output int cnt);
    logic [3:0] ev;
    cnt = 0;
    ev = 4'h0;
    while (!ev[sel] && cnt < 1000) begin
      @(posedge hclk);
      ev = {fsm_in.rate_locked, fsm_out.restart_search, fsm_out.reconfig_req, fsm_out.hangup};
      cnt++;
    end
    chk(32'(ev[sel]), 32'h1);
  endtask

  // offered rate must stay inside the active group
  task automatic scan(input logic [7:0] mask);
    int bad;
    bad = 0;
    repeat (40) begin
      @(posedge hclk);
      if (mask[fsm_out.rate_option] !== 1'b1) bad++;
    end
    chk(32'(bad), 32'h0);
  endtask

  task automatic t_regs;
    rd(`LRNR_FULLSET_OFS);
    chk(q, 32'h1F);
    rd(`LRNR_SETA_OFS);
    chk(q, 32'h0F);
    rd(`LRNR_SETB_OFS);
    chk(q, 32'h1E);
    rd(`LRNR_PASS_OFS);
    chk(q, 32'h404);
    rd(`LRNR_IRQCLR_OFS);
    chk(q, 32'h0);
    rd(12'h040);
    chk(q, 32'h0);
    $display("test regs done");
  endtask

  task automatic t_lock;
    lock_rate <= 3'h2;
    lock_en <= 1'b1;
    wr(`LRNR_IRQEN_OFS, 32'hF);
    wr(`LRNR_CTRL_OFS, 32'h1);
    wait_ev(3, n);
    repeat (2) @(posedge hclk);
    rd(`LRNR_STATUS_OFS);
    chk(q & 32'hFF037, 32'(LRNR_LINKED));
    chk(32'(irq), 32'h1);
    wr(`LRNR_IRQEN_OFS, 32'h0);
    repeat (2) @(posedge hclk);
    chk(32'(irq), 32'h0);
    wr(`LRNR_IRQEN_OFS, 32'hF);
    wr(`LRNR_IRQCLR_OFS, 32'hF);
    rd(`LRNR_IRQSTS_OFS);
    chk(q, 32'h0);
    chk(32'(irq), 32'h0);
    $display("test lock done");
  endtask

  task automatic t_recfg;
    wr(`LRNR_FINAL_OFS, 32'h5);
    wr(`LRNR_CTRL_OFS, 32'h11);
    neg_req <= 1'b1;
    wait_ev(1, n);
    chk(32'(fsm_out.reconfig_rate), 32'h5);
    @(posedge hclk);
    chk(32'(cur_rate), 32'h5);
    rd(`LRNR_IRQSTS_OFS);
    chk(32'(q[3]), 32'h1);
    neg_req <= 1'b0;
    lock_en <= 1'b0;
    $display("test reconfig done");
  endtask

  task automatic t_reduce;
    wr(`LRNR_CTRL_OFS, 32'h0);
    wr(`LRNR_CTRL_OFS, 32'h9);
    wait_ev(0, n);
    wait_ev(2, n);
    scan(8'h0F);
    rd(`LRNR_STATUS_OFS);
    chk(32'(q[5:4]), 32'h1);
    wait_ev(0, n);
    wait_ev(2, n);
    scan(8'h1E);
    rd(`LRNR_STATUS_OFS);
    chk(32'(q[5:4]), 32'h2);
    $display("test reduce done");
  endtask

  task automatic t_timer;
    wr(`LRNR_CTRL_OFS, 32'h0);
    wr(`LRNR_CTRL_OFS, 32'h5);
    wait_ev(0, n);
    chk(32'(n > 190 && n < 230), 32'h1);
    $display("test timer done");
  endtask

  task automatic t_wait;
    wr(`LRNR_CTRL_OFS, 32'h0);
    wr(`LRNR_CTRL_OFS, 32'h3);
    wait_ev(0, n);
    rd(`LRNR_STATUS_OFS);
    chk(32'(q[2:0]), 32'(LRNR_WAIT));
    wait_ev(2, g1);
    rd(`LRNR_STATUS_OFS);
    chk(32'(q[19:12]), 32'h0);
    chk(32'(q[23:20]), 32'h1);
    wait_ev(0, n);
    wait_ev(2, n);
    // longer second wait, doubled base
    chk(32'(n > g1 + 10), 32'h1);
    $display("test wait done");
  endtask

  task automatic t_small;
    wr(`LRNR_CTRL_OFS, 32'h0);
    wr(`LRNR_FULLSET_OFS, 32'h0F);
    wr(`LRNR_IRQCLR_OFS, 32'hF);
    wr(`LRNR_CTRL_OFS, 32'h1);
    repeat (400) @(posedge hclk);
    rd(`LRNR_IRQSTS_OFS);
    chk(32'(q[0]), 32'h0);
    $display("test small set done");
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge hclk);
    err_total++;
    give_verdict;
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    lock_en = 1'b0;
    lock_rate = 3'h0;
    neg_req = 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs;
    t_lock;
    t_recfg;
    t_reduce;
    t_timer;
    t_wait;
    t_small;
    give_verdict;
  end
endmodule
